// *** pkg/mii_port_defs.svh ***
// Constants for the MII port block
`ifndef MII_PORT_DEFS_SVH
`define MII_PORT_DEFS_SVH
`define SYS_PERIOD_NS     25
`define MDC_HALF_NS       200
`define MDC_HALF_CYC      ((`MDC_HALF_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define MGMT_PRE_BITS     32
`define MGMT_FRAME_BITS   32
`define MGMT_TA_BIT       14
`define MGMT_DATA_BIT     16
`define SYNC_W            11
`define SYNC_RX_CLK       0
`define SYNC_RXD_LSB      1
`define SYNC_RX_VALID     5
`define SYNC_RX_ERR       6
`define SYNC_TX_CLK       7
`define SYNC_CRS          8
`define SYNC_CLSN         9
`define SYNC_MDIO         10
`endif

// *** pkg/mii_port_pkg.sv ***
// Types for the MII port block
package mii_port_pkg;
	typedef struct packed {
		logic       valid;
		logic [3:0] data;
	} nibble_s;
	typedef struct packed {
		logic        crc_err;
		logic [15:0] nibble_count;
	} rx_descriptor_status_word_s;
	typedef struct packed {
		logic        start;
		logic        read;
		logic [31:0] frame;
	} mgmt_cmd_s;
	typedef enum logic [1:0] {
		M_IDLE,
		M_PRE,
		M_FRAME
	} mgmt_state_e;
endpackage

// *** hw/mii_port.sv ***
// MAC-side MII port: receive, transmit, status sync and management
`timescale 1ns/1ps
`include "mii_port_defs.svh"
module mii_port
	import mii_port_pkg::*;
(
	input  wire logic                                    i_clk_sys,
	input  wire logic                                    i_rst,
	input  wire logic                                    i_rx_clk,
	input  wire logic [3:0]                              i_rxd,
	input  wire logic                                    i_rx_valid_in,
	input  wire logic                                    i_rx_err,
	input  wire logic                                    i_crs,
	input  wire logic                                    i_clsn,
	input  wire logic                                    i_tx_clk,
	output logic [3:0]                                   o_txd,
	output logic                                         o_tx_en,
	output logic                                         o_mdc,
	input  wire logic                                    i_mdio,
	output logic                                         o_mdio,
	output logic                                         o_mdio_oe,
	output logic                                         o_port_mii,
	input  wire logic                                    i_port_sel_mii,
	output mii_port_pkg::nibble_s                        o_rx_nibble,
	output logic                                         o_rx_end,
	output mii_port_pkg::rx_descriptor_status_word_s     o_rx_status,
	input  wire mii_port_pkg::nibble_s                   i_tx_nibble,
	output logic                                         o_tx_ready,
	output logic                                         o_crs,
	output logic                                         o_clsn,
	input  wire mii_port_pkg::mgmt_cmd_s                 i_mgmt_cmd,
	output logic                                         o_mgmt_busy,
	output logic                                         o_mgmt_done,
	output logic [15:0]                                  o_mgmt_rdata
);
	import mii_port_pkg::*;

	// Two-flop synchronisers for the PHY-side pin inputs; i_port_sel_mii is registered only once
	logic [`SYNC_W-1:0] sync1_r, sync2_r, sync_d, sync1_nxt, sync2_nxt;
	logic               rx_clk_prev_r, rx_clk_prev_nxt, tx_clk_prev_r, tx_clk_prev_nxt;
	logic               rx_rise, tx_rise;

	assign sync_d = {i_mdio, i_clsn, i_crs, i_tx_clk, i_rx_err, i_rx_valid_in, i_rxd, i_rx_clk};

	always_comb begin
		sync1_nxt       = sync_d;
		sync2_nxt       = sync1_r;
		rx_clk_prev_nxt = sync2_r[`SYNC_RX_CLK];
		tx_clk_prev_nxt = sync2_r[`SYNC_TX_CLK];
		if (i_rst) begin
			sync1_nxt       = '0;
			sync2_nxt       = '0;
			rx_clk_prev_nxt = 1'b0;
			tx_clk_prev_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		sync1_r       <= sync1_nxt;
		sync2_r       <= sync2_nxt;
		rx_clk_prev_r <= rx_clk_prev_nxt;
		tx_clk_prev_r <= tx_clk_prev_nxt;
	end

	assign rx_rise = sync2_r[`SYNC_RX_CLK] & ~rx_clk_prev_r;
	assign tx_rise = sync2_r[`SYNC_TX_CLK] & ~tx_clk_prev_r;
	assign o_crs   = sync2_r[`SYNC_CRS];
	assign o_clsn  = sync2_r[`SYNC_CLSN];

	// Receive path
	nibble_s                    rx_nib_r, rx_nib_nxt;
	logic                       in_pkt_r, in_pkt_nxt, rx_end_r, rx_end_nxt;
	rx_descriptor_status_word_s acc_r, acc_nxt, stat_r, stat_nxt;
	logic                       dv_s, err_s;

	assign dv_s = sync2_r[`SYNC_RX_VALID];
	assign err_s = sync2_r[`SYNC_RX_ERR];

	always_comb begin
		rx_nib_nxt       = rx_nib_r;
		rx_nib_nxt.valid = 1'b0;
		in_pkt_nxt       = in_pkt_r;
		rx_end_nxt       = 1'b0;
		acc_nxt          = acc_r;
		stat_nxt         = stat_r;
		if (rx_rise) begin
			if (dv_s) begin
				rx_nib_nxt.valid = 1'b1;
				rx_nib_nxt.data  = sync2_r[`SYNC_RXD_LSB +: 4];
				in_pkt_nxt       = 1'b1;
				acc_nxt.nibble_count = in_pkt_r ? acc_r.nibble_count + 16'h0001 : 16'h0001;
				acc_nxt.crc_err      = (in_pkt_r & acc_r.crc_err) | err_s;
			end else if (in_pkt_r) begin
				in_pkt_nxt = 1'b0;
				rx_end_nxt = 1'b1;
				stat_nxt   = acc_r;
			end
		end
		if (i_rst) begin
			rx_nib_nxt = '0;
			in_pkt_nxt = 1'b0;
			rx_end_nxt = 1'b0;
			acc_nxt    = '0;
			stat_nxt   = '0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		rx_nib_r <= rx_nib_nxt;
		in_pkt_r <= in_pkt_nxt;
		rx_end_r <= rx_end_nxt;
		acc_r    <= acc_nxt;
		stat_r   <= stat_nxt;
	end

	assign o_rx_nibble = rx_nib_r;
	assign o_rx_end    = rx_end_r;
	assign o_rx_status = stat_r;

	// Transmit path and port select
	logic [3:0] txd_r, txd_nxt;
	logic       tx_en_r, tx_en_nxt, port_r, port_nxt;

	assign o_tx_ready = tx_rise;

	always_comb begin
		txd_nxt   = txd_r;
		tx_en_nxt = tx_en_r;
		port_nxt  = i_port_sel_mii;
		if (tx_rise) begin
			tx_en_nxt = i_tx_nibble.valid;
			txd_nxt   = i_tx_nibble.valid ? i_tx_nibble.data : 4'h0;
		end
		if (i_rst) begin
			txd_nxt   = 4'h0;
			tx_en_nxt = 1'b0;
			port_nxt  = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		txd_r   <= txd_nxt;
		tx_en_r <= tx_en_nxt;
		port_r  <= port_nxt;
	end

	assign o_txd      = txd_r;
	assign o_tx_en    = tx_en_r;
	assign o_port_mii = port_r;

	// Management interface
	mgmt_state_e st_r, st_nxt;
	logic [7:0]  div_r, div_nxt;
	logic [5:0]  bit_r, bit_nxt;
	logic [31:0] sh_r, sh_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic        mdc_r, mdc_nxt, rd_op_r, rd_op_nxt, done_r, done_nxt, tog;

	assign tog = (div_r == 8'(`MDC_HALF_CYC - 1));

	always_comb begin
		st_nxt    = st_r;
		div_nxt   = 8'h00;
		bit_nxt   = bit_r;
		sh_nxt    = sh_r;
		rd_nxt    = rd_r;
		mdc_nxt   = mdc_r;
		rd_op_nxt = rd_op_r;
		done_nxt  = 1'b0;
		unique case (st_r)
			M_IDLE: begin
				mdc_nxt = 1'b0;
				if (i_mgmt_cmd.start) begin
					st_nxt    = M_PRE;
					sh_nxt    = i_mgmt_cmd.frame;
					rd_op_nxt = i_mgmt_cmd.read;
					bit_nxt   = 6'h00;
				end
			end
			M_PRE, M_FRAME: begin
				div_nxt = tog ? 8'h00 : div_r + 8'h01;
				if (tog) begin
					mdc_nxt = ~mdc_r;
					if (!mdc_r && st_r == M_FRAME && rd_op_r && bit_r >= 6'(`MGMT_DATA_BIT)) begin
						rd_nxt = {rd_r[14:0], sync2_r[`SYNC_MDIO]};
					end
					if (mdc_r) begin
						bit_nxt = bit_r + 6'h01;
						if (st_r == M_FRAME) begin
							sh_nxt = {sh_r[30:0], 1'b0};
						end
						if (bit_r == 6'(`MGMT_PRE_BITS - 1) && st_r == M_PRE) begin
							st_nxt  = M_FRAME;
							bit_nxt = 6'h00;
						end else if (bit_r == 6'(`MGMT_FRAME_BITS - 1)) begin
							st_nxt   = M_IDLE;
							done_nxt = 1'b1;
						end
					end
				end
			end
		endcase
		if (i_rst) begin
			st_nxt    = M_IDLE;
			div_nxt   = 8'h00;
			bit_nxt   = 6'h00;
			sh_nxt    = 32'h0000_0000;
			rd_nxt    = 16'h0000;
			mdc_nxt   = 1'b0;
			rd_op_nxt = 1'b0;
			done_nxt  = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		st_r    <= st_nxt;
		div_r   <= div_nxt;
		bit_r   <= bit_nxt;
		sh_r    <= sh_nxt;
		rd_r    <= rd_nxt;
		mdc_r   <= mdc_nxt;
		rd_op_r <= rd_op_nxt;
		done_r  <= done_nxt;
	end

	assign o_mdc        = mdc_r;
	assign o_mdio       = (st_r == M_PRE) ? 1'b1 : sh_r[31];
	assign o_mdio_oe    = (st_r == M_PRE) || (st_r == M_FRAME && !(rd_op_r && bit_r >= 6'(`MGMT_TA_BIT)));
	assign o_mgmt_busy  = (st_r != M_IDLE);
	assign o_mgmt_done  = done_r;
	assign o_mgmt_rdata = rd_r;
endmodule

// *** verification/mii_phy_model.sv ***
// PHY partner model for the MII port
`timescale 1ns/1ps
module mii_phy_model (
	input  wire logic       i_mdc,
	input  wire logic       i_mdio_oe,
	input  wire logic       i_mdio_drv,
	input  wire logic [3:0] i_txd,
	input  wire logic       i_tx_en,
	output logic            o_md_line,
	output logic            o_rx_clk,
	output logic [3:0]      o_rxd,
	output logic            o_rx_valid,
	output logic            o_rx_err,
	output logic            o_crs,
	output logic            o_tx_clk
);
	logic       md_r;
	logic [3:0]  txq[$];
	logic [31:0] wr_sh;
	initial begin
		{o_rx_clk, o_rxd, o_rx_valid, o_rx_err, o_crs, o_tx_clk} = '0;
		md_r = 1'b1;
		#7;
		forever #100 o_tx_clk = ~o_tx_clk;
	end
	always @(posedge o_tx_clk) if (i_tx_en) txq.push_back(i_txd);
	always @(posedge i_mdc) md_r <= i_mdio_oe ? 1'b1 : ~md_r;
	always @(posedge i_mdc) if (i_mdio_oe) wr_sh <= {wr_sh[30:0], i_mdio_drv};
	assign o_md_line = i_mdio_oe ? i_mdio_drv : md_r;
	task automatic send(input int n, input logic [3:0] base, input int bad);
		#3;
		o_crs <= 1'b1;
		for (int i = 0; i <= n + 1; i++) begin
			o_rx_valid <= (i < n);
			o_rxd <= (i < n) ? base + 4'(i) : ~o_rxd;
			o_rx_err <= (i == bad);
			#100 o_rx_clk = 1'b1;
			#100 o_rx_clk = 1'b0;
		end
		o_crs <= 1'b0;
	endtask
endmodule

// *** verification/mii_port_props.sv ***
// Assertions for the MII port
`timescale 1ns/1ps
`include "mii_port_defs.svh"
module mii_port_props
	import mii_port_pkg::*;
(
	input wire logic                    i_clk_sys,
	input wire logic                    i_rst,
	input wire logic [3:0]              i_rxd,
	input wire logic                    i_rx_valid_in,
	input wire logic                    i_crs,
	input wire logic                    i_clsn,
	input wire logic                    i_port_sel_mii,
	input wire mii_port_pkg::nibble_s   i_tx_nibble,
	input wire logic [3:0]              o_txd,
	input wire logic                    o_tx_en,
	input wire logic                    o_tx_ready,
	input wire logic                    o_mdc,
	input wire logic                    o_mdio,
	input wire logic                    o_mdio_oe,
	input wire logic                    o_port_mii,
	input wire mii_port_pkg::nibble_s   o_rx_nibble,
	input wire logic                    o_rx_end,
	input wire logic                    o_crs,
	input wire logic                    o_clsn,
	input wire logic                    o_mgmt_busy,
	input wire logic                    o_mgmt_done
);
	localparam int MGMT_CYC = 2 * `MDC_HALF_CYC * (`MGMT_PRE_BITS + `MGMT_FRAME_BITS);
	// Cycles spent busy in the current management frame
	logic [10:0] mgmt_cyc_r;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || !o_mgmt_busy) begin
			mgmt_cyc_r <= 11'h000;
		end else begin
			mgmt_cyc_r <= mgmt_cyc_r + 11'h001;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	AST_CRS_SYNC: assert property (i_crs [*2] |=> o_crs) else $error("carrier sync");
	AST_CLSN_SYNC: assert property (!i_clsn [*2] |=> !o_clsn) else $error("collision sync");
	AST_PORT_SEL: assert property (1'b1 |=> o_port_mii == $past(i_port_sel_mii)) else $error("port select");
	AST_TX_EN: assert property (o_tx_ready |=> o_tx_en == $past(i_tx_nibble.valid)) else $error("tx enable");
	AST_TXD: assert property (o_tx_ready && i_tx_nibble.valid |=> o_txd == $past(i_tx_nibble.data))
		else $error("tx data");
	AST_TX_HOLD: assert property (!o_tx_ready |=> $stable(o_txd) && $stable(o_tx_en)) else $error("tx hold");
	AST_RX_GATE: assert property (o_rx_nibble.valid |-> $past(i_rx_valid_in, 4) && o_rx_nibble.data == $past(i_rxd, 4))
		else $error("rx sample");
	AST_RX_PULSE: assert property (o_rx_nibble.valid |=> !o_rx_nibble.valid) else $error("rx pulse");
	AST_MDC_HALF: assert property ($rose(o_mdc) |-> o_mdc [*8] ##1 !o_mdc) else $error("mdc period");
	AST_MGMT_START: assert property ($rose(o_mgmt_busy) |-> o_mdio_oe && o_mdio && !o_mdc) else $error("mdio drive");
	AST_MGMT_DONE: assert property (o_mgmt_done |-> mgmt_cyc_r == 11'(MGMT_CYC)) else $error("mgmt done");
	AST_MGMT_BOUND: assert property (o_mgmt_busy |-> mgmt_cyc_r < 11'(MGMT_CYC)) else $error("mgmt hang");
	COV_RX_END: cover property (o_rx_end);
	COV_TX: cover property (o_tx_ready && i_tx_nibble.valid);
	COV_MGMT: cover property (o_mgmt_done);
endmodule
bind mii_port mii_port_props chk (.*);

// *** verification/tb.sv ***
// Bench for the MII port
`timescale 1ns/1ps
module tb;
	import mii_port_pkg::*;
	logic                       i_clk_sys, i_rst, i_rx_clk, i_rx_valid_in, i_rx_err, i_crs, i_clsn, i_tx_clk, i_mdio;
	logic                       i_port_sel_mii, o_tx_en, o_mdc, o_mdio, o_mdio_oe, o_port_mii, o_rx_end, o_tx_ready;
	logic                       o_crs, o_clsn, o_mgmt_busy, o_mgmt_done;
	logic [3:0]                 i_rxd, o_txd, rxq[$];
	logic [15:0]                o_mgmt_rdata;
	nibble_s                    o_rx_nibble, i_tx_nibble;
	rx_descriptor_status_word_s o_rx_status;
	mgmt_cmd_s                  i_mgmt_cmd;
	int                         err_count, checks_done, ends;
	mii_port uut (.*);
	mii_phy_model phy (.i_mdc(o_mdc), .i_mdio_oe(o_mdio_oe), .i_mdio_drv(o_mdio), .i_txd(o_txd), .i_tx_en(o_tx_en),
		.o_md_line(i_mdio), .o_rx_clk(i_rx_clk), .o_rxd(i_rxd), .o_rx_valid(i_rx_valid_in), .o_rx_err(i_rx_err),
		.o_crs(i_crs), .o_tx_clk(i_tx_clk));
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			err_count++;
			print_verdict();
		end
	endtask
	always @(posedge i_clk_sys) begin
		if (o_rx_nibble.valid === 1'b1) rxq.push_back(o_rx_nibble.data);
		if (o_rx_end === 1'b1) ends++;
	end
	task automatic t_pins();
		for (int k = 0; k < 4; k++) begin
			i_clsn <= k[0];
			i_port_sel_mii <= k[1];
			repeat (3) @(posedge i_clk_sys);
			chk(o_clsn, k[0]);
			chk(o_port_mii, k[1]);
		end
	endtask
	task automatic t_rx();
		int b;
		for (int p = 0; p < 2; p++) begin
			b = rxq.size();
			phy.send(5 + p, 4'h3 + 4'(p), p ? 2 : 99);
			chk(ends, p + 1);
			chk(o_rx_status, {1'(p), 16'(5 + p)});
			chk(rxq.size() - b, 5 + p);
			for (int i = 0; i < 5 + p; i++) chk(rxq[b + i], 4'h3 + 4'(p) + 4'(i));
		end
	endtask
	task automatic t_tx();
		int n, idx;
		@(posedge i_clk_sys);
		i_tx_nibble <= {1'b1, 4'h9};
		idx = 0;
		for (n = 0; n < 400 && idx < 5; n++) begin
			@(posedge i_clk_sys);
			if (o_tx_ready === 1'b1) begin
				idx++;
				i_tx_nibble <= (idx < 4) ? {1'b1, 4'h9 + 4'(idx)} : '0;
			end
		end
		tmo(n, 400);
		repeat (40) @(posedge i_clk_sys);
		chk(phy.txq.size(), 4);
		foreach (phy.txq[i]) chk(phy.txq[i], 4'h9 + 4'(i));
	endtask
	task automatic t_mgmt();
		int n;
		for (int w = 0; w < 2; w++) begin
			@(posedge i_clk_sys);
			i_mgmt_cmd <= {1'b1, 1'(w == 0), w ? 32'h5002_1234 : 32'h6002_0000};
			@(posedge i_clk_sys);
			i_mgmt_cmd.start <= 1'b0;
			for (n = 0; n < 1100 && o_mgmt_done !== 1'b1; n++) @(posedge i_clk_sys);
			tmo(n, 1100);
			chk(o_mgmt_rdata, 16'haaaa);
			if (w) begin
				chk(phy.wr_sh[31:16], 16'h5002);
				chk(phy.wr_sh[15:0], 16'h1234);
			end
		end
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_rst = 1'b1;
		i_clsn = 1'b0;
		i_port_sel_mii = 1'b0;
		i_tx_nibble = '0;
		i_mgmt_cmd = '0;
		repeat (8) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		t_pins();
		t_rx();
		t_tx();
		t_mgmt();
		print_verdict();
	end
endmodule
